// ### logic/config_rom_bus_info_regs.sv
`default_nettype none
`include "rom_regs_defs.svh"
module config_rom_bus_info_regs
    import rom_regs_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,

    // Software reset pulse and link state
    input wire logic soft_reset,
    input wire logic link_on_bit,

    // Host register port
    input wire host_req_type host_req,
    output logic [31:0] rd_data,

    // Remote configuration ROM reads
    input wire rom_req_type rom_req,
    output rom_resp_type rom_resp,

    // Current register images
    output rom_header_type rom_header,
    output bus_options_type bus_options,
    output logic [16:0] max_rec_bytes,
    output logic [2:0] rom_status
);

    // ============================================================
    // Write decode

    logic wr_header;
    logic wr_ident;
    logic wr_options;
    logic wr_status;
    logic rd_hit;

    always_comb
    begin
        wr_header = host_req.wr && (host_req.addr == `OFS_ROM_HEADER);
        wr_ident = host_req.wr && (host_req.addr == `OFS_BUS_IDENT);
        wr_options = host_req.wr && (host_req.addr == `OFS_BUS_OPTIONS);
        wr_status = host_req.wr && (host_req.addr == `OFS_ROM_STATUS);
        rd_hit = host_req.rd;
    end

    // ============================================================
    // Header word fields

    logic [7:0] info_length;
    logic [7:0] crc_length;
    logic [15:0] rom_crc;

    rw_field #(
        .WIDTH(8),
        .RESET_VALUE(`INFO_LEN_RESET),
        .KEEP_ON_SOFT(1'b0)
    ) u_info_length (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .write(wr_header), // [R2]
        .write_data(host_req.wdata[`INFO_LEN_LSB +: 8]), // [R2]
        .value(info_length)
    ); // [R4]

    rw_field #(
        .WIDTH(8),
        .RESET_VALUE(`CRC_LEN_RESET),
        .KEEP_ON_SOFT(1'b0)
    ) u_crc_length (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .write(wr_header),
        .write_data(host_req.wdata[`CRC_LEN_LSB +: 8]), // [R2]
        .value(crc_length)
    ); // [R4]

    // No defined reset value is promised to software; zero is loaded
    // so that simulation never carries unknowns
    rw_field #(
        .WIDTH(16),
        .RESET_VALUE(`ROM_CRC_RESET),
        .KEEP_ON_SOFT(1'b0)
    ) u_rom_crc (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .write(wr_header),
        .write_data(host_req.wdata[`ROM_CRC_LSB +: 16]), // [R2]
        .value(rom_crc)
    ); // [R4]

    // ============================================================
    // Bus options fields

    logic [4:0] caps;
    logic [7:0] cyc_clk_acc;
    logic [3:0] max_rec;
    logic [3:0] gen_field;

    rw_field #(
        .WIDTH(5),
        .RESET_VALUE(`CAPS_RESET),
        .KEEP_ON_SOFT(1'b0)
    ) u_caps (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .write(wr_options),
        .write_data(host_req.wdata[`CAPS_LSB +: 5]), // [R8]
        .value(caps)
    ); // [R8]

    rw_field #(
        .WIDTH(8),
        .RESET_VALUE(`CYC_ACC_RESET),
        .KEEP_ON_SOFT(1'b0)
    ) u_cyc_clk_acc (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .write(wr_options),
        .write_data(host_req.wdata[`CYC_ACC_LSB +: 8]),
        .value(cyc_clk_acc)
    );

    // Survives soft reset so the advertised block size never glitches
    rw_field #(
        .WIDTH(4),
        .RESET_VALUE(`MAX_REC_RESET),
        .KEEP_ON_SOFT(1'b1)
    ) u_max_rec (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .write(wr_options),
        .write_data(host_req.wdata[`MAX_REC_LSB +: 4]),
        .value(max_rec)
    ); // [R9]

    rw_field #(
        .WIDTH(4),
        .RESET_VALUE(`GEN_RESET),
        .KEEP_ON_SOFT(1'b0)
    ) u_gen_field (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .soft_reset(soft_reset),
        .write(wr_options),
        .write_data(host_req.wdata[`GEN_LSB +: 4]),
        .value(gen_field)
    );

    // ============================================================
    // Assembled words; read-only bits are constants, never written

    rom_header_type header_image;
    bus_options_type options_image;
    logic [31:0] ident_image;

    always_comb
    begin
        header_image.info_length = info_length;
        header_image.crc_length = crc_length;
        header_image.rom_crc = rom_crc;
        options_image.caps = caps;
        options_image.rsvd_hi = `OPT_RSVD_HI; // [R10]
        options_image.cyc_clk_acc = cyc_clk_acc;
        options_image.max_rec = max_rec;
        options_image.rsvd_mid = `OPT_RSVD_MID; // [R10]
        options_image.gen_field = gen_field;
        options_image.link_speed = `LINK_SPEED_VALUE; // [R10]
        ident_image = `BUS_IDENT_VALUE; // [R5]
    end

    // ============================================================
    // Status flags and mirrors

    logic link_seen;
    logic ro_write_seen;
    logic live_write_seen;
    logic next_link_seen;
    logic next_ro_write_seen;
    logic next_live_write_seen;
    logic [16:0] next_max_rec_bytes;
    rom_header_type next_rom_header;
    bus_options_type next_bus_options;
    logic ro_touch;

    // A write that tries to change a read-only bit is flagged, not applied
    always_comb
    begin
        ro_touch = wr_ident && (host_req.wdata != ident_image); // [R10]
        if (wr_options)
        begin
            if (host_req.wdata[26:24] != `OPT_RSVD_HI ||
                host_req.wdata[11:8] != `OPT_RSVD_MID ||
                host_req.wdata[3:0] != `LINK_SPEED_VALUE)
            begin
                ro_touch = 1'b1; // [R10]
            end
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_comb
    begin
        next_link_seen = link_on_bit;
        next_ro_write_seen = ro_write_seen;
        next_live_write_seen = live_write_seen;
        if (soft_reset)
        begin
            next_ro_write_seen = 1'b0;
            next_live_write_seen = 1'b0;
        end
        else
        begin
            if (wr_status && host_req.wdata[`STAT_RO_WRITE_BIT])
            begin
                next_ro_write_seen = 1'b0;
            end
            if (wr_status && host_req.wdata[`STAT_LIVE_WRITE_BIT])
            begin
                next_live_write_seen = 1'b0;
            end
            if (ro_touch)
            begin
                next_ro_write_seen = 1'b1;
            end
            // Changing ROM contents while the link is on breaks the
            // host's promise to keep them valid; remember it
            if ((wr_header || wr_options) && link_on_bit)
            begin
                next_live_write_seen = 1'b1; // [R3]
            end
        end
        next_max_rec_bytes = 17'(17'h00001 << (5'(max_rec) + 5'h01)); // [R9]
        next_rom_header = header_image;
        next_bus_options = options_image;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            link_seen <= 1'b0;
            ro_write_seen <= 1'b0;
            live_write_seen <= 1'b0;
            max_rec_bytes <= 17'h00800;
            rom_header <= '0;
            // Image shows the reset pattern at once, matching the byte limit
            bus_options <= {`CAPS_RESET, `OPT_RSVD_HI, `CYC_ACC_RESET, `MAX_REC_RESET,
                `OPT_RSVD_MID, `GEN_RESET, `LINK_SPEED_VALUE}; // [R7]
        end
        else if (ce)
        begin
            link_seen <= next_link_seen;
            ro_write_seen <= next_ro_write_seen;
            live_write_seen <= next_live_write_seen;
            max_rec_bytes <= next_max_rec_bytes;
            rom_header <= next_rom_header;
            bus_options <= next_bus_options;
        end
    end

    // ============================================================
    // Host read data, valid only in the cycle after the strobe

    logic [31:0] next_rd_data;
    logic [2:0] next_rom_status;

    always_comb
    begin
        next_rd_data = 32'h00000000;
        next_rom_status = {live_write_seen, ro_write_seen, link_seen};
        if (rd_hit)
        begin
            case (host_req.addr)
                `OFS_ROM_HEADER: next_rd_data = header_image; // [R2]
                `OFS_BUS_IDENT: next_rd_data = ident_image; // [R5]
                `OFS_BUS_OPTIONS: next_rd_data = options_image; // [R7]
                `OFS_ROM_STATUS: next_rd_data = {29'h00000000, next_rom_status};
                default: next_rd_data = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rd_data <= 32'h00000000;
            rom_status <= 3'h0;
        end
        else if (ce)
        begin
            rd_data <= next_rd_data;
            rom_status <= next_rom_status;
        end
    end

    // ============================================================
    // Remote quadlet reads

    rom_quadlet_port u_rom_port (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .link_on(link_on_bit),
        .header_word(header_image),
        .ident_word(ident_image),
        .options_word(options_image),
        .req(rom_req),
        .resp(rom_resp)
    ); // [R1] [R6]

endmodule
`default_nettype wire

// ### logic/rom_quadlet_port.sv
`default_nettype none
`include "rom_regs_defs.svh"
module rom_quadlet_port
    import rom_regs_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Link state
    input wire logic link_on,
    // Register images
    input wire logic [31:0] header_word,
    input wire logic [31:0] ident_word,
    input wire logic [31:0] options_word,
    // Remote quadlet read
    input wire rom_req_type req,
    output rom_resp_type resp
);

    rom_resp_type next_resp;

    // Quadlets are only served while the link is on, since contents
    // are guaranteed valid by the host only then
    always_comb
    begin
        next_resp = '0;
        if (req.rd)
        begin
            next_resp.ack = 1'b1;
            if (!link_on) // [R3]
            begin
                next_resp.err = 1'b1;
            end
            else
            begin
                case (req.offset)
                    `ROM_ADDR_HEADER: next_resp.data = header_word; // [R1]
                    `ROM_ADDR_IDENT: next_resp.data = ident_word; // [R6]
                    `ROM_ADDR_OPTIONS: next_resp.data = options_word; // [R7]
                    default: next_resp.err = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            resp <= '0;
        end
        else if (ce)
        begin
            resp <= next_resp;
        end
    end

endmodule
`default_nettype wire

// ### logic/rom_regs_defs.svh
// Function
// R1 - Header word is answered as configuration ROM quadlet at bus address FFFF F000 0400h.
// R2 - Header word holds info length 31-24, checked length 23-16, ROM check 15-0.
// R3 - Host keeps header and options valid before and while the link is on.
// R4 - Reset clears both length fields; ROM check value has no defined reset.
// R5 - Bus identification word at 1Ch always reads 3133 3934h.
// R6 - Bus identification word is answered as first bus information block quadlet.
// R7 - Bus options word at 20h is second block quadlet, reset pattern X0XX A0X2h.
// R8 - Five capability flags in bits 31-27 are read/write and reset to zero.
// R9 - Max request field 15-12 is Ah after hardware reset, kept on soft reset.
// R10 - Host writes to read-only bits are ignored; those bits keep fixed values.
`ifndef ROM_REGS_DEFS_SVH
`define ROM_REGS_DEFS_SVH

// ============================================================
// Host register offsets
`define OFS_ROM_HEADER 8'h18
`define OFS_BUS_IDENT 8'h1c
`define OFS_BUS_OPTIONS 8'h20
`define OFS_ROM_STATUS 8'h24

// ============================================================
// Configuration ROM space seen by remote nodes
`define ROM_SPACE_BASE 48'hfffff0000000
`define ROM_ADDR_HEADER 12'h400
`define ROM_ADDR_IDENT 12'h404
`define ROM_ADDR_OPTIONS 12'h408

// ============================================================
// Header word fields
`define INFO_LEN_LSB 24
`define CRC_LEN_LSB 16
`define ROM_CRC_LSB 0
`define INFO_LEN_RESET 8'h00
`define CRC_LEN_RESET 8'h00
`define ROM_CRC_RESET 16'h0000

// ============================================================
// Fixed identification word, ASCII "1394"
`define BUS_IDENT_VALUE 32'h31333934

// ============================================================
// Bus options fields
`define CAPS_LSB 27
`define CAPS_RESET 5'h00
`define OPT_RSVD_HI 3'h0
`define CYC_ACC_LSB 16
`define CYC_ACC_RESET 8'h00
`define MAX_REC_LSB 12
`define MAX_REC_RESET 4'ha
`define OPT_RSVD_MID 4'h0
`define GEN_LSB 4
`define GEN_RESET 4'h0
`define LINK_SPEED_VALUE 4'h2

// ============================================================
// Status register bits
`define STAT_LINK_BIT 0
`define STAT_RO_WRITE_BIT 1
`define STAT_LIVE_WRITE_BIT 2

`endif

// ### logic/rom_regs_pkg.sv
`default_nettype none
package rom_regs_pkg;

    // ============================================================
    // Register images
    typedef struct packed {
        logic [7:0] info_length;
        logic [7:0] crc_length;
        logic [15:0] rom_crc;
    } rom_header_type;

    typedef struct packed {
        logic [4:0] caps;
        logic [2:0] rsvd_hi;
        logic [7:0] cyc_clk_acc;
        logic [3:0] max_rec;
        logic [3:0] rsvd_mid;
        logic [3:0] gen_field;
        logic [3:0] link_speed;
    } bus_options_type;

    // ============================================================
    // Request and answer carriers
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } host_req_type;

    typedef struct packed {
        logic rd;
        logic [11:0] offset;
    } rom_req_type;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] data;
    } rom_resp_type;

endpackage
`default_nettype wire

// ### logic/rw_field.sv
`default_nettype none
module rw_field #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0,
    parameter bit KEEP_ON_SOFT = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Control
    input wire logic soft_reset,
    input wire logic write,
    input wire logic [WIDTH-1:0] write_data,
    // Stored value
    output logic [WIDTH-1:0] value
);

    logic [WIDTH-1:0] next_value;

    // Soft reset beats a write in the same cycle
    always_comb
    begin
        next_value = value;
        if (soft_reset)
        begin
            if (!KEEP_ON_SOFT)
            begin
                next_value = RESET_VALUE;
            end
        end
        else if (write)
        begin
            next_value = write_data;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            value <= RESET_VALUE;
        end
        else if (ce)
        begin
            value <= next_value;
        end
    end

endmodule
`default_nettype wire

// ### test/config_rom_bus_info_regs_chk.sv
`default_nettype none
module config_rom_bus_info_regs_chk
    import rom_regs_pkg::*;
(
    // Clock and controls
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic soft_reset,
    input wire logic link_on_bit,
    // Host and remote ports
    input wire host_req_type host_req,
    input wire logic [31:0] rd_data,
    input wire rom_req_type rom_req,
    input wire rom_resp_type rom_resp,
    // Images
    input wire rom_header_type rom_header,
    input wire bus_options_type bus_options,
    input wire logic [16:0] max_rec_bytes,
    input wire logic [2:0] rom_status
);
    // ========
    // Properties
    default clocking cb @(posedge clock);
    endclocking
    // A frozen clock enable would stall every answer, so checks pause with it
    default disable iff (!rst_n || !ce);

    property p_ident;
        host_req.rd && host_req.addr == 8'h1c |=> rd_data == 32'h31333934;
    endproperty
    a_ident: assert property (p_ident) else $error("ident read wrong");

    property p_ack;
        rom_resp.ack == $past(rom_req.rd);
    endproperty
    a_ack: assert property (p_ack) else $error("remote ack timing wrong");

    sequence s_ok(logic [11:0] o);
        rom_req.rd && link_on_bit && rom_req.offset == o;
    endsequence

    property p_hdr_q;
        s_ok(12'h400) |=> !rom_resp.err && rom_resp.data == rom_header;
    endproperty
    a_hdr_q: assert property (p_hdr_q) else $error("header quadlet wrong");

    property p_ident_q;
        s_ok(12'h404) |=> !rom_resp.err && rom_resp.data == 32'h31333934;
    endproperty
    a_ident_q: assert property (p_ident_q) else $error("ident quadlet wrong");

    property p_opt_q;
        s_ok(12'h408) |=> !rom_resp.err && rom_resp.data == bus_options;
    endproperty
    a_opt_q: assert property (p_opt_q) else $error("options quadlet wrong");

    property p_opt_fixed;
        $past(rst_n) |-> bus_options.rsvd_hi == 3'h0 && bus_options.rsvd_mid == 4'h0
            && bus_options.link_speed == 4'h2;
    endproperty
    a_opt_fixed: assert property (p_opt_fixed) else $error("fixed bits moved");

    property p_max_bytes;
        max_rec_bytes == 17'h1 << (bus_options.max_rec + 5'h1);
    endproperty
    a_max_bytes: assert property (p_max_bytes) else $error("byte limit wrong");

    property p_soft_clr;
        soft_reset |=> ##1 rom_header.info_length == 8'h0 && rom_header.crc_length == 8'h0
            && bus_options.caps == 5'h0;
    endproperty
    a_soft_clr: assert property (p_soft_clr) else $error("soft reset kept fields");

    property p_soft_keep;
        soft_reset |=> ##1 $stable(bus_options.max_rec);
    endproperty
    a_soft_keep: assert property (p_soft_keep) else $error("soft reset hit max_rec");

    c_rom: cover property (s_ok(12'h400));
    c_soft_wr: cover property (soft_reset && host_req.wr);
    c_max_f: cover property (bus_options.max_rec == 4'hf);
endmodule
`default_nettype wire

// ### test/config_rom_bus_info_regs_tb.sv
`default_nettype none
module config_rom_bus_info_regs_tb;
    import rom_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic soft_reset = 1'b0;
    logic link_on_bit = 1'b0;
    logic start = 1'b0;
    logic [11:0] offset = 12'h0;
    host_req_type host_req = '0;
    rom_req_type rom_req;
    rom_resp_type rom_resp;
    rom_resp_type got;
    rom_header_type rom_header;
    bus_options_type bus_options;
    logic [31:0] rd_data;
    logic [31:0] hdr_m;
    logic [31:0] opt_m;
    logic [31:0] d;
    logic [16:0] max_rec_bytes;
    logic [2:0] rom_status;
    logic done;
    int n_fail = 0;
    int cmp_count = 0;

    config_rom_bus_info_regs dut_u (.clock(clock), .rst_n(rst_n), .ce(ce),
        .soft_reset(soft_reset), .link_on_bit(link_on_bit), .host_req(host_req),
        .rd_data(rd_data), .rom_req(rom_req), .rom_resp(rom_resp), .rom_header(rom_header),
        .bus_options(bus_options), .max_rec_bytes(max_rec_bytes), .rom_status(rom_status));
    remote_node node_u (.clock(clock), .rst_n(rst_n), .start(start), .offset(offset),
        .req(rom_req), .resp(rom_resp), .got(got), .done(done));

    // ========
    // Helpers
    function automatic logic [31:0] opt_f(input logic [31:0] v);
        return (v & 32'hf8fff0f0) | 32'h2;
    endfunction

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Write leaves the strobe up so a following read is back to back
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        host_req <= '{1'b0, 1'b1, a, v};
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clock);
        host_req <= '{1'b1, 1'b0, a, 32'h0};
        @(posedge clock);
        host_req <= '0;
        #1;
        chk("rd_data", e & m, rd_data & m);
    endtask

    task automatic rom(input logic [11:0] o, input logic [31:0] e, input logic err);
        int i;
        @(posedge clock);
        host_req <= '0;
        start <= 1'b1;
        offset <= o;
        @(posedge clock);
        start <= 1'b0;
        for (i = 0; i < 8; i++)
        begin
            @(posedge clock);
            #1;
            if (done === 1'b1)
                break;
        end
        if (done !== 1'b1)
        begin
            n_fail++;
            $display("[FAIL] rom_done expected 1 seen 0");
            final_report();
        end
        else
        begin
            chk("rom_data", e, got.data);
            chk("rom_err", 32'(err), 32'(got.err));
        end
    endtask

    initial forever #12.5 clock = ~clock;

    // ========
    // Tests
    initial
    begin
        d = $urandom(38);
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rd(8'h18, 32'h0, 32'hffff0000);
        rd(8'h1c, 32'h31333934, '1);
        rd(8'h20, 32'h0000a002, '1);
        rd(8'h40, 32'h0, '1);
        chk("max_rec_bytes", 32'h800, 32'(max_rec_bytes));
        $display("test reset_values done");
        for (int i = 0; i < 22; i++)
        begin
            d = $urandom();
            hdr_m = d;
            wr(8'h18, d);
            rd(8'h18, hdr_m, '1);
            chk("info_length", 32'(hdr_m[31:24]), 32'(rom_header.info_length));
            d = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $urandom();
            opt_m = opt_f(d);
            wr(8'h20, d);
            wr(8'h1c, ~d);
            rd(8'h20, opt_m, '1);
            rd(8'h1c, 32'h31333934, '1);
            chk("max_rec_bytes", 32'h1 << (opt_m[15:12] + 5'h1), 32'(max_rec_bytes));
        end
        rd(8'h24, 32'h2, '1);
        chk("rom_status", 32'h2, 32'(rom_status));
        wr(8'h24, 32'h2);
        rd(8'h24, 32'h0, '1);
        $display("test host_access done");
        @(posedge clock);
        link_on_bit <= 1'b1;
        rom(12'h400, hdr_m, 1'b0);
        rom(12'h404, 32'h31333934, 1'b0);
        rom(12'h408, opt_m, 1'b0);
        rom(12'h40c, 32'h0, 1'b1);
        rd(8'h24, 32'h1, '1);
        chk("rom_status", 32'h1, 32'(rom_status));
        @(posedge clock);
        link_on_bit <= 1'b0;
        rom(12'h400, 32'h0, 1'b1);
        $display("test remote_reads done");
        @(posedge clock);
        soft_reset <= 1'b1;
        host_req <= '{1'b0, 1'b1, 8'h20, 32'hffffffff};
        @(posedge clock);
        soft_reset <= 1'b0;
        host_req <= '0;
        opt_m = (opt_m & 32'h0000f000) | 32'h2;
        rd(8'h18, 32'h0, 32'hffff0000);
        rd(8'h20, opt_m, '1);
        $display("test soft_reset done");
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(8'h20, 32'h0000a002, '1);
        rd(8'h18, 32'h0, 32'hffff0000);
        $display("test hard_reset done");
        final_report();
    end
endmodule

bind config_rom_bus_info_regs config_rom_bus_info_regs_chk chk_u (.clock(clock),
    .rst_n(rst_n), .ce(ce), .soft_reset(soft_reset), .link_on_bit(link_on_bit),
    .host_req(host_req), .rd_data(rd_data), .rom_req(rom_req), .rom_resp(rom_resp),
    .rom_header(rom_header), .bus_options(bus_options), .max_rec_bytes(max_rec_bytes),
    .rom_status(rom_status));
`default_nettype wire

// ### test/remote_node.sv
`default_nettype none
module remote_node
    import rom_regs_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Command
    input wire logic start,
    input wire logic [11:0] offset,
    // ROM port
    output rom_req_type req,
    input wire rom_resp_type resp,
    // Result
    output rom_resp_type got,
    output logic done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;

    // ========
    // One quadlet read per start
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            done <= 1'b0;
            phase <= 2'd0;
            req <= '0;
            got <= '0;
        end
        else if (phase == 2'd0)
        begin
            done <= 1'b0;
            if (start)
            begin
                req <= '{1'b1, offset};
                phase <= 2'd1;
            end
        end
        else if (phase == 2'd1)
        begin
            // Offset flipped so a stale value is never mistaken for a held one
            done <= 1'b0;
            req <= '{1'b0, ~req.offset};
            phase <= 2'd2;
        end
        else
        begin
            got <= resp;
            done <= 1'b1;
            phase <= 2'd0;
        end
    end
endmodule
`default_nettype wire
